// ### rtl/dcs_top.sv
// control logic of a two-counter four-digit stopwatch/timer with a wishbone slave
`timescale 1ns/1ps
`default_nettype none
module dcs_top #(
    parameter int PRESET_DIV = dcs_pkg::PRESET_CYCLES,
    parameter int DEBOUNCE_DIV = dcs_pkg::DEBOUNCE_CYCLES
) (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // option and control pins, active low
    input wire logic [6:0] FUNC_SEL_N,
    input wire logic [2:0] SCALE_SEL_N,
    input wire logic MATCH_EN_N,
    input wire logic RUN_TOGGLE_N,
    input wire logic CLEAR_N,
    input wire logic LAST_EVENT_N,
    input wire logic [3:0] PRESET_DIGIT_N,
    // preset digit 4 doubles as standby indicator
    output logic STANDBY_O,
    output logic STANDBY_OE,
    // counter clock and cascade pins
    input wire logic COUNT_TICK,
    input wire logic COUNT1_ENABLE_IN_N,
    input wire logic COUNT2_ENABLE_IN_N,
    output logic COUNT1_FULL_OUT_O,
    output logic COUNT1_FULL_OUT_OE,
    output logic COUNT2_FULL_OUT_O,
    output logic COUNT2_FULL_OUT_OE,
    // display and comparator
    output dcs_pkg::dcs_disp_s DISP,
    output logic MATCH_OUT
);
    logic [20:0] sync1;
    logic [20:0] sync2;
    logic [6:0] fsel_n;
    logic [2:0] scale;
    logic cmp_on;
    logic [3:0] ev_raw;
    logic [3:0] ev;
    logic [3:0] prog_n;
    logic c1en_n;
    logic c2en_n;
    logic tick_s;
    logic tick_q;
    logic tick;
    logic [2:0] fn;
    logic f15;
    logic ev_run;
    logic ev_clear;
    logic ev_last;
    logic sw_wr;
    logic [31:0] prescnt;
    logic preset_en;
    logic [1:0] settle;
    logic lock;
    logic standby_done;
    logic dp_cleared;
    dcs_pkg::dcs_state_e state;
    dcs_pkg::dcs_state_e next_state;
    // local aliases, since nothing is imported from the package
    localparam dcs_pkg::dcs_state_e ST_IDLE = dcs_pkg::ST_IDLE;
    localparam dcs_pkg::dcs_state_e ST_RUN = dcs_pkg::ST_RUN;
    localparam dcs_pkg::dcs_state_e ST_HOLD = dcs_pkg::ST_HOLD;
    localparam dcs_pkg::dcs_state_e ST_MATCH = dcs_pkg::ST_MATCH;
    localparam dcs_pkg::dcs_state_e ST_FINAL = dcs_pkg::ST_FINAL;
    logic run1;
    logic run2;
    logic show_c2;
    logic live;
    logic blank_all;
    logic next_run1;
    logic next_run2;
    logic next_show_c2;
    logic next_live;
    logic next_blank_all;
    logic clr1;
    logic clr2;
    logic load_held;
    logic hit;
    logic [15:0] c1;
    logic [15:0] c2;
    logic [15:0] held;
    logic [3:0] m6_c1;
    logic [3:0] m6_c2;
    logic [15:0] shown;
    logic full1;
    logic full2;

    function automatic logic [3:0] mod6_mask(input logic [2:0] code, input logic second);
        logic [3:0] m;
        m = 4'h0;
        if (!code[2] || second) begin
            unique case (code[1:0])
                2'b01: m = 4'h8;
                2'b10: m = 4'h4;
                2'b11: m = 4'h2;
                default: m = 4'h0;
            endcase
        end
        return m;
    endfunction

    function automatic logic [3:0] digit_top(input logic six);
        return six ? dcs_pkg::DIGIT_TOP_SIX : dcs_pkg::DIGIT_TOP_DEC;
    endfunction

    // ripple step through four bcd digits, wrapping each at its own modulus
    function automatic logic [15:0] bcd_step(input logic [15:0] v, input logic [3:0] m6, input logic down);
        logic [15:0] r;
        logic carry;
        logic [3:0] d;
        logic [3:0] top;
        r = v;
        carry = 1'b1;
        for (int i = 0; i < 4; i++) begin
            d = v[4*i +: 4];
            top = digit_top(m6[i]);
            if (carry) begin
                if (down) begin
                    r[4*i +: 4] = (d == 4'h0) ? top : d - 4'h1;
                    carry = (d == 4'h0);
                end else begin
                    r[4*i +: 4] = (d >= top) ? 4'h0 : d + 4'h1;
                    carry = (d >= top);
                end
            end
        end
        return r;
    endfunction

    function automatic logic is_full(input logic [15:0] v, input logic [3:0] m6);
        logic f;
        f = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if (v[4*i +: 4] != digit_top(m6[i])) begin
                f = 1'b0;
            end
        end
        return f;
    endfunction

    // every option, control and counter pin is foreign to CLOCK, so all pass two flops first
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            sync1 <= 21'h1FFFFF;
            sync2 <= 21'h1FFFFF;
        end else begin
            sync1 <= {COUNT_TICK, COUNT2_ENABLE_IN_N, COUNT1_ENABLE_IN_N, PRESET_DIGIT_N, LAST_EVENT_N, CLEAR_N,
                      RUN_TOGGLE_N, MATCH_EN_N, SCALE_SEL_N, FUNC_SEL_N};
            sync2 <= sync1;
        end
    end

    assign fsel_n = sync2[6:0];
    assign scale = ~sync2[9:7];
    assign cmp_on = ~sync2[10];
    assign ev_raw = {sync2[14], sync2[13], sync2[12], sync2[11]};
    assign prog_n = sync2[17:14];
    assign c1en_n = sync2[18];
    assign c2en_n = sync2[19];
    assign tick_s = sync2[20];

    // lowest selected function wins; none selected runs function 1
    always_comb begin
        fn = dcs_pkg::FN_1;
        for (int i = 6; i >= 0; i--) begin
            if (!fsel_n[i]) begin
                fn = 3'(i);
            end
        end
    end
    assign f15 = (fn <= dcs_pkg::FN_5);

    // one debouncer per momentary input: run, clear, last, latch
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_deb
            logic stable;
            logic [31:0] cnt;
            always_ff @(posedge CLOCK or negedge RST_N) begin
                if (!RST_N) begin
                    stable <= 1'b1;
                    cnt <= 32'h0;
                    ev[gi] <= 1'b0;
                end else begin
                    ev[gi] <= 1'b0;
                    if (ev_raw[gi] == stable) begin
                        cnt <= 32'h0;
                    end else if (cnt >= 32'(DEBOUNCE_DIV - 1)) begin
                        cnt <= 32'h0;
                        stable <= ev_raw[gi];
                        ev[gi] <= stable;
                    end else begin
                        cnt <= cnt + 32'h1;
                    end
                end
            end
        end
    endgenerate

    // software events share the pin path, taken on the acked edge
    assign sw_wr = WB_CYC_I & WB_STB_I & WB_ACK_O & WB_WE_I & WB_SEL_I[0] & (WB_ADR_I == dcs_pkg::ADDR_CTRL);
    assign ev_run = ev[0] | (sw_wr & WB_DAT_I[dcs_pkg::CTRL_RUN_BIT]);
    assign ev_clear = ev[1] | (sw_wr & WB_DAT_I[dcs_pkg::CTRL_CLEAR_BIT]);
    assign ev_last = ev[2] | (sw_wr & WB_DAT_I[dcs_pkg::CTRL_LAST_BIT]);

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= tick_s;
        end
    end
    assign tick = tick_s & ~tick_q;

    // preset step rate divider
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            prescnt <= 32'h0;
            preset_en <= 1'b0;
        end else begin
            preset_en <= (prescnt >= 32'(PRESET_DIV - 1));
            prescnt <= (prescnt >= 32'(PRESET_DIV - 1)) ? 32'h0 : prescnt + 32'h1;
        end
    end

    // comparator strap caught once the synchronisers have settled after reset
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            settle <= 2'h0;
            lock <= 1'b0;
        end else if (settle != 2'h3) begin
            settle <= settle + 2'h1;
            lock <= (settle == 2'h2) & cmp_on;
        end else if (ev_clear && (!cmp_on || fn == dcs_pkg::FN_6)) begin
            lock <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            standby_done <= 1'b0;
            dp_cleared <= 1'b0;
        end else if (ev_run) begin
            standby_done <= 1'b1;
            dp_cleared <= 1'b1;
        end
    end

    assign hit = cmp_on && state == ST_RUN
                 && ((fn == dcs_pkg::FN_6 && c2 == c1) || (fn == dcs_pkg::FN_7 && c1 == dcs_pkg::BCD_ZERO));

    always_comb begin
        next_state = state;
        next_run1 = run1;
        next_run2 = run2;
        next_show_c2 = show_c2;
        next_live = live;
        next_blank_all = blank_all;
        clr1 = 1'b0;
        clr2 = 1'b0;
        load_held = 1'b0;
        if (ev_clear) begin
            next_state = ST_IDLE;
            next_run1 = 1'b0;
            next_run2 = 1'b0;
            clr2 = 1'b1;
            clr1 = (fn != dcs_pkg::FN_6);
            next_show_c2 = 1'b0;
            next_live = 1'b1;
            next_blank_all = f15;
        end else if (ev_last && (state == ST_RUN || state == ST_HOLD)) begin
            next_state = ST_FINAL;
            next_run1 = 1'b0;
            next_run2 = 1'b0;
            next_show_c2 = (fn != dcs_pkg::FN_7);
            next_live = 1'b1;
        end else if (hit) begin
            next_state = ST_MATCH;
            next_run1 = 1'b0;
            next_run2 = 1'b0;
            next_show_c2 = (fn == dcs_pkg::FN_6);
        end else if (ev_run) begin
            unique case (state)
                ST_IDLE: begin
                    if (!(lock && fn <= dcs_pkg::FN_6)) begin
                        next_state = ST_RUN;
                        next_blank_all = 1'b0;
                        next_live = 1'b1;
                        next_run2 = (fn != dcs_pkg::FN_7);
                        next_run1 = f15 ? (fn != dcs_pkg::FN_4) : (fn == dcs_pkg::FN_7);
                        next_show_c2 = (fn != dcs_pkg::FN_7);
                    end
                end
                ST_RUN: begin
                    if (fn == dcs_pkg::FN_3 || fn == dcs_pkg::FN_4) begin
                        load_held = 1'b1;
                        next_live = 1'b0;
                        clr2 = (fn == dcs_pkg::FN_3);
                    end else if (fn != dcs_pkg::FN_7) begin
                        next_state = ST_HOLD;
                        next_run2 = 1'b0;
                        next_run1 = (fn != dcs_pkg::FN_2) && (fn != dcs_pkg::FN_6) && run1;
                        next_show_c2 = (fn != dcs_pkg::FN_6);
                    end
                end
                ST_HOLD: begin
                    next_state = ST_RUN;
                    next_run2 = 1'b1;
                    next_show_c2 = 1'b1;
                    next_run1 = (fn != dcs_pkg::FN_6);
                    clr2 = (fn == dcs_pkg::FN_1 || fn == dcs_pkg::FN_2);
                end
                ST_MATCH: begin
                    next_state = ST_MATCH;
                end
                ST_FINAL: begin
                    if (fn != dcs_pkg::FN_7) begin
                        next_show_c2 = ~show_c2;
                    end
                end
            endcase
        end else if (ev[3] && (fn == dcs_pkg::FN_3 || fn == dcs_pkg::FN_4) && state == ST_RUN) begin
            next_live = 1'b1;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            state <= ST_IDLE;
            run1 <= 1'b0;
            run2 <= 1'b0;
            show_c2 <= 1'b0;
            live <= 1'b1;
            blank_all <= 1'b1;
        end else begin
            state <= next_state;
            run1 <= next_run1;
            run2 <= next_run2;
            show_c2 <= next_show_c2;
            live <= next_live;
            blank_all <= next_blank_all;
        end
    end

    assign m6_c1 = mod6_mask(scale, 1'b0);
    assign m6_c2 = mod6_mask(scale, 1'b1);

    // counter 1: counts, or takes preset steps in functions 6 and 7 while idle
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            c1 <= dcs_pkg::BCD_ZERO;
        end else if (clr1) begin
            c1 <= dcs_pkg::BCD_ZERO;
        end else if (run1 && tick && !c1en_n) begin
            c1 <= bcd_step(c1, m6_c1, fn == dcs_pkg::FN_7);
        end else if (!f15 && state == ST_IDLE && preset_en) begin
            for (int i = 0; i < 4; i++) begin
                if (!prog_n[i]) begin
                    // single digit wraps alone, no carry onward
                    c1[4*i +: 4] <= (c1[4*i +: 4] >= digit_top(m6_c1[i])) ? 4'h0 : c1[4*i +: 4] + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            c2 <= dcs_pkg::BCD_ZERO;
        end else if (clr2) begin
            c2 <= dcs_pkg::BCD_ZERO;
        end else if (run2 && tick && !c2en_n) begin
            c2 <= bcd_step(c2, m6_c2, 1'b0);
        end
    end

    // held copy of counter 2 for split display
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            held <= dcs_pkg::BCD_ZERO;
        end else if (load_held) begin
            held <= c2;
        end
    end

    assign full1 = is_full(c1, m6_c1);
    assign full2 = is_full(c2, m6_c2);
    assign COUNT1_FULL_OUT_O = 1'b0;
    assign COUNT1_FULL_OUT_OE = full1;
    assign COUNT2_FULL_OUT_O = 1'b0;
    assign COUNT2_FULL_OUT_OE = full2;
    assign STANDBY_O = standby_done;
    assign STANDBY_OE = f15;
    assign shown = show_c2 ? (live ? c2 : held) : c1;

    // display register; the units digit is never zero-blanked
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            DISP <= '0;
            MATCH_OUT <= 1'b0;
        end else begin
            DISP.bcd <= shown;
            DISP.show_c2 <= show_c2;
            DISP.dp <= f15 & ~dp_cleared;
            MATCH_OUT <= (state == ST_MATCH) && (fn == dcs_pkg::FN_6 || fn == dcs_pkg::FN_7);
            if (blank_all && f15) begin
                DISP.blank <= 4'hF;
            end else if (f15 || show_c2) begin
                DISP.blank[3] <= (shown[15:12] == 4'h0);
                DISP.blank[2] <= (shown[15:8] == 8'h00);
                DISP.blank[1] <= (shown[15:4] == 12'h000);
                DISP.blank[0] <= 1'b0;
            end else begin
                DISP.blank <= 4'h0;
            end
        end
    end

    // wishbone slave: one wait state, unmapped reads give zero
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0;
        end else begin
            WB_ACK_O <= WB_CYC_I & WB_STB_I & ~WB_ACK_O;
            if (WB_CYC_I && WB_STB_I && !WB_ACK_O) begin
                unique case (WB_ADR_I)
                    dcs_pkg::ADDR_COUNT: WB_DAT_O <= {c2, c1};
                    dcs_pkg::ADDR_STATUS: WB_DAT_O <= {17'h0, fn, 3'h0, 3'(state), MATCH_OUT, lock,
                                                       standby_done, show_c2, run2, run1};
                    default: WB_DAT_O <= 32'h0;
                endcase
            end
        end
    end
endmodule // dcs_top
`default_nettype wire

// ### rtl/dcs_pkg.sv
// shared constants and types for the dual counter stopwatch control
package dcs_pkg;
    localparam int CLK_PERIOD_NS = 25;
    localparam int PRESET_PERIOD_NS = 400_000_000;
    localparam int PRESET_CYCLES = PRESET_PERIOD_NS / CLK_PERIOD_NS;
    localparam int DEBOUNCE_NS = 1_000_000;
    localparam int DEBOUNCE_CYCLES = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_COUNT = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_CLEAR_BIT = 1;
    localparam int CTRL_LAST_BIT = 2;
    localparam logic [15:0] BCD_ZERO = 16'h0000;
    localparam logic [3:0] DIGIT_TOP_DEC = 4'h9;
    localparam logic [3:0] DIGIT_TOP_SIX = 4'h5;
    localparam logic [2:0] FN_1 = 3'h0;
    localparam logic [2:0] FN_2 = 3'h1;
    localparam logic [2:0] FN_3 = 3'h2;
    localparam logic [2:0] FN_4 = 3'h3;
    localparam logic [2:0] FN_5 = 3'h4;
    localparam logic [2:0] FN_6 = 3'h5;
    localparam logic [2:0] FN_7 = 3'h6;
    typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_HOLD, ST_MATCH, ST_FINAL} dcs_state_e;
    typedef struct packed {
        logic [15:0] bcd;
        logic [3:0] blank;
        logic dp;
        logic show_c2;
    } dcs_disp_s;
endpackage

// ### dv/dcs_chk_assertions.sv
// concurrent checks on the stopwatch control ports
`timescale 1ns/1ps
`default_nettype none
module dcs_chk (
    // clock, reset and bus
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_ACK_O,
    // pins
    input wire logic [6:0] FUNC_SEL_N,
    input wire logic STANDBY_O,
    input wire logic STANDBY_OE,
    input wire logic COUNT1_FULL_OUT_O,
    input wire logic COUNT1_FULL_OUT_OE,
    input wire logic COUNT2_FULL_OUT_O,
    input wire dcs_pkg::dcs_disp_s DISP
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    logic f67;
    logic [3:0] lz;
    assign f67 = (&FUNC_SEL_N[4:0]) && !(&FUNC_SEL_N[6:5]);
    // units digit is never zero-blanked, so bit 0 stays clear
    assign lz = {DISP.bcd[15:12] == 4'h0, DISP.bcd[15:8] == 8'h00, DISP.bcd[15:4] == 12'h000, 1'b0};
    ack_one_cycle_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    ack_wait_one_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("ack not one cycle after request");
    full1_drain_a: assert property (!COUNT1_FULL_OUT_O)
        else $error("full 1 drives high");
    full2_drain_a: assert property (!COUNT2_FULL_OUT_O)
        else $error("full 2 drives high");
    standby_stick_a: assert property (STANDBY_O |=> STANDBY_O)
        else $error("standby indicator dropped");
    standby_drive_a: assert property ($stable(FUNC_SEL_N)[*4] ##0 $past(RST_N, 3) |-> STANDBY_OE == !f67)
        else $error("standby drive wrong for function");
    // the pin synchronisers read all ones until two edges after reset, so the view settles three edges on
    power_view_a: assert property ($rose(RST_N) |-> ##3 (f67 ? (DISP.bcd == 16'h0000 && DISP.blank == 4'h0)
        : (DISP.blank == 4'hF && DISP.dp)))
        else $error("power-on view wrong");
    lead_blank_a: assert property (DISP.show_c2 && DISP.blank != 4'hF |-> DISP.blank == lz)
        else $error("counter 2 leading zero blanking wrong");
    c1_unblank_a: assert property (f67 && $past(RST_N, 3) && !DISP.show_c2 |-> DISP.blank == 4'h0)
        else $error("counter 1 blanked in 6 or 7");
    cover property (WB_ACK_O);
    cover property (COUNT1_FULL_OUT_OE);
    cover property (DISP.show_c2 && DISP.blank != 4'hF);
endmodule // dcs_chk
`default_nettype wire

// ### dv/dcs_far.sv
// far side: switches, cascaded second chip and pin pull-ups
`timescale 1ns/1ps
`default_nettype none
module dcs_far (
    // from the bench
    input wire logic hold1,
    input wire logic [3:0] press,
    // from the block
    input wire logic stby_o,
    input wire logic stby_oe,
    input wire logic full1_o,
    input wire logic full1_oe,
    input wire logic full2_o,
    input wire logic full2_oe,
    // to the block and to the second chip
    output logic en1_n,
    output logic en2_n,
    output logic [3:0] pd_n,
    output logic casc1_n,
    output logic casc2_n
);
    // counter 1 enable is only lifted for a stall test and for the closing function 7 clear
    assign en1_n = hold1;
    assign en2_n = 1'b0;
    assign pd_n[2:0] = ~press[2:0];
    // open switch pulls up, so the standby drive decides the shared pin
    assign pd_n[3] = stby_oe ? stby_o : ~press[3];
    assign casc1_n = full1_oe ? full1_o : 1'b1;
    assign casc2_n = full2_oe ? full2_o : 1'b1;
endmodule // dcs_far
`default_nettype wire

// ### dv/testbench.sv
// self-checking bench for the stopwatch control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct packed {logic [2:0] ssel; logic [31:0] cnt;} dcs_row_s;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] dat_o;
    logic [6:0] fsel_n = 7'h7F;
    logic [2:0] ssel_n = 3'h7;
    logic [2:0] ev_n = 3'h7;
    logic match_n = 1'b1;
    logic tick = 1'b0;
    logic hold1 = 1'b0;
    logic [3:0] press = 4'h0;
    logic [3:0] pd_n;
    logic ack, stby_o, stby_oe, en1_n, en2_n, f1o, f1oe, f2o, f2oe, casc1_n, casc2_n, mout;
    dcs_pkg::dcs_disp_s disp;
    int failures = 0;
    int samples_checked = 0;
    dcs_row_s rows [8] = '{'{3'h7, 32'h06600660}, '{3'h6, 32'h06600660}, '{3'h5, 32'h10601060},
        '{3'h4, 32'h11001100}, '{3'h3, 32'h06600660}, '{3'h2, 32'h06600660},
        '{3'h1, 32'h10600660}, '{3'h0, 32'h11000660}};
    always #12.5 clk = ~clk;
    dcs_top #(.PRESET_DIV(32), .DEBOUNCE_DIV(4)) i_dut (.CLOCK(clk), .RST_N(rst_n), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat),
        .WB_DAT_O(dat_o), .WB_ACK_O(ack), .FUNC_SEL_N(fsel_n), .SCALE_SEL_N(ssel_n),
        .MATCH_EN_N(match_n), .RUN_TOGGLE_N(ev_n[0]), .CLEAR_N(ev_n[1]), .LAST_EVENT_N(ev_n[2]),
        .PRESET_DIGIT_N(pd_n), .STANDBY_O(stby_o), .STANDBY_OE(stby_oe), .COUNT_TICK(tick),
        .COUNT1_ENABLE_IN_N(en1_n), .COUNT2_ENABLE_IN_N(en2_n), .COUNT1_FULL_OUT_O(f1o),
        .COUNT1_FULL_OUT_OE(f1oe), .COUNT2_FULL_OUT_O(f2o), .COUNT2_FULL_OUT_OE(f2oe),
        .DISP(disp), .MATCH_OUT(mout));
    dcs_far i_far (.hold1(hold1), .press(press), .stby_o(stby_o), .stby_oe(stby_oe),
        .full1_o(f1o), .full1_oe(f1oe), .full2_o(f2o), .full2_oe(f2oe), .en1_n(en1_n),
        .en2_n(en2_n), .pd_n(pd_n), .casc1_n(casc1_n), .casc2_n(casc2_n));
    task automatic close_out;
        if (failures == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic cyc_n(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        i = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
            i++;
        end while (ack !== 1'b1 && i < 20);
        if (ack !== 1'b1) begin
            chk(32'h0, 32'h1, "no ack");
            close_out();
        end
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask
    task automatic ev(input int b);
        wb(1'b1, dcs_pkg::ADDR_CTRL, 32'h1 << b);
        cyc_n(2);
    endtask
    task automatic rd_cnt(input logic [31:0] exp, input string w);
        wb(1'b0, dcs_pkg::ADDR_COUNT, 32'h0);
        chk(rdat, exp, w);
    endtask
    task automatic pulse(input int which, input int len);
        ev_n[which] <= 1'b0;
        cyc_n(len);
        ev_n <= 3'h7;
        cyc_n(12);
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            tick <= 1'b1;
            cyc_n(2);
            tick <= 1'b0;
            cyc_n(2);
        end
        cyc_n(4);
    endtask
    // holds one switch until the digit reads the target; a slow step rate keeps overshoot out
    task automatic preset(input int d, input logic [3:0] tgt);
        int i;
        i = 0;
        press[d] <= 1'b1;
        do begin
            wb(1'b0, dcs_pkg::ADDR_COUNT, 32'h0);
            i++;
        end while (rdat[4*d +: 4] !== tgt && i < 400);
        press <= 4'h0;
        if (i >= 400) begin
            chk(32'h0, 32'h1, "preset stuck");
            close_out();
        end
        cyc_n(4);
    endtask
    initial begin
        cyc_n(10);
        rst_n <= 1'b1;
        cyc_n(4);
        chk(32'(stby_o), 32'h0, "standby at power-on");
        chk(32'(disp.blank), 32'hF, "power-on blank");
        wb(1'b1, dcs_pkg::ADDR_COUNT, 32'hFFFFFFFF);
        rd_cnt(32'h0, "write to count ignored");
        wb(1'b0, 8'h0C, 32'h0);
        chk(rdat, 32'h0, "unmapped read");
        foreach (rows[k]) begin
            ssel_n <= rows[k].ssel;
            ev(dcs_pkg::CTRL_CLEAR_BIT);
            ev(dcs_pkg::CTRL_RUN_BIT);
            ticks(660);
            ev(dcs_pkg::CTRL_LAST_BIT);
            ticks(2);
            rd_cnt(rows[k].cnt, "scaled count");
        end
        chk(32'(stby_o), 32'h1, "standby after toggles");
        ssel_n <= 3'h7;
        ev(dcs_pkg::CTRL_CLEAR_BIT);
        pulse(0, 2);
        ticks(2);
        rd_cnt(32'h0, "glitch started count");
        hold1 <= 1'b1;
        pulse(0, 10);
        ticks(5);
        pulse(0, 10);
        hold1 <= 1'b0;
        ticks(3);
        rd_cnt(32'h00050003, "stop counter 2");
        chk(32'(disp.show_c2), 32'h1, "held counter 2 shown");
        pulse(0, 10);
        ticks(2);
        rd_cnt(32'h00020005, "restart counter 2");
        pulse(2, 10);
        ticks(2);
        rd_cnt(32'h00020005, "last event stops both");
        chk(32'(disp.show_c2), 32'h1, "counter 2 after last");
        pulse(0, 10);
        chk(32'(disp.show_c2), 32'h0, "display swap");
        pulse(1, 10);
        rd_cnt(32'h0, "reset pin clears");
        rst_n <= 1'b0;
        fsel_n <= 7'h5F;
        match_n <= 1'b0;
        cyc_n(10);
        rst_n <= 1'b1;
        cyc_n(4);
        ev(dcs_pkg::CTRL_RUN_BIT);
        ticks(3);
        rd_cnt(32'h0, "locked start");
        match_n <= 1'b1;
        ev(dcs_pkg::CTRL_CLEAR_BIT);
        for (int d = 0; d < 4; d++) preset(d, 4'h9);
        rd_cnt(32'h00009999, "preset to full");
        chk(32'(f1oe), 32'h1, "full 1 at max");
        chk(32'(casc1_n), 32'h0, "cascade enable at max");
        preset(0, 4'h0);
        rd_cnt(32'h00009990, "no preset carry");
        chk(32'(f1oe), 32'h0, "full 1 released");
        ev(dcs_pkg::CTRL_CLEAR_BIT);
        rd_cnt(32'h00009990, "function 6 keeps preset");
        match_n <= 1'b0;
        ev(dcs_pkg::CTRL_RUN_BIT);
        ticks(3);
        rd_cnt(32'h00039990, "unlocked start");
        match_n <= 1'b1;
        hold1 <= 1'b1;
        fsel_n <= 7'h3F;
        cyc_n(4);
        ev(dcs_pkg::CTRL_CLEAR_BIT);
        rd_cnt(32'h0, "function 7 reset clears");
        close_out();
    end
endmodule // testbench
bind dcs_top dcs_chk i_chk (.CLOCK(CLOCK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_ACK_O(WB_ACK_O), .FUNC_SEL_N(FUNC_SEL_N), .STANDBY_O(STANDBY_O), .STANDBY_OE(STANDBY_OE),
    .COUNT1_FULL_OUT_O(COUNT1_FULL_OUT_O), .COUNT1_FULL_OUT_OE(COUNT1_FULL_OUT_OE),
    .COUNT2_FULL_OUT_O(COUNT2_FULL_OUT_O), .DISP(DISP));
`default_nettype wire
